//--- rtl/pbmc_map.vh
// register layout and timing constants for the basic mode control register
// assumes inclusion by both design files of the block
`ifndef PBMC_MAP_VH
`define PBMC_MAP_VH
`define PBMC_ADDR_BMC 5'h00
`define PBMC_BIT_RESET 15
`define PBMC_BIT_LOOP 14
`define PBMC_BIT_SPEED 13
`define PBMC_BIT_ANEN 12
`define PBMC_BIT_PDOWN 11
`define PBMC_BIT_ISO 10
`define PBMC_BIT_RESTART 9
`define PBMC_BIT_DUPLEX 8
`define PBMC_BIT_COLTEST 7
`define PBMC_RST_SPEED 1'h1
`define PBMC_RST_ANEN 1'h1
`define PBMC_RST_DUPLEX 1'h1
`define PBMC_RST_ZERO 1'h0
`define PBMC_RESET_NS 1000
`define PBMC_RESET_CYC ((`PBMC_RESET_NS + 9) / 10)
`define PBMC_MDIO_OP_WR 2'h1
`define PBMC_MDIO_OP_RD 2'h2
`define PBMC_PHYADDR 5'h01
`endif

//--- rtl/pbmc_mdio_slave.v
// serial management frame slave: decodes write frames, serves read frames
// assumes mdc is sampled as a synchronous input on mclk
`timescale 1ns/100ps
`include "pbmc_map.vh"
module pbmc_mdio_slave (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // management pins
  input wire mdc,
  input wire mdioIn,
  output reg mdioOut,
  output reg mdioOe,
  // register side
  input wire [4:0] phyAddr,
  input wire [15:0] rdData,
  output reg wrStb,
  output reg rdStb,
  output reg [4:0] regAddr,
  output reg [15:0] wrData
);
  localparam S_PRE = 3'h0;
  localparam S_HDR = 3'h1;
  localparam S_TA = 3'h2;
  localparam S_WDAT = 3'h3;
  localparam S_RDAT = 3'h4;
  reg [2:0] state_r;
  reg mdcPrev_r;
  reg [5:0] cnt_r;
  reg [13:0] hdr_r;
  reg [15:0] shift_r;
  wire rise = mdc & ~mdcPrev_r;
  wire fall = ~mdc & mdcPrev_r;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_PRE;
      mdcPrev_r <= 1'h0;
      cnt_r <= 6'h00;
      hdr_r <= 14'h0000;
      shift_r <= 16'h0000;
      mdioOut <= 1'h0;
      mdioOe <= 1'h0;
      wrStb <= 1'h0;
      rdStb <= 1'h0;
      regAddr <= 5'h00;
      wrData <= 16'h0000;
    end else begin
      mdcPrev_r <= mdc;
      wrStb <= 1'h0;
      rdStb <= 1'h0;
      case (state_r)
        S_PRE: begin
          mdioOe <= 1'h0;
          if (rise) begin
            // 32 ones of preamble; a zero after them starts the frame
            if (mdioIn) begin
              if (cnt_r != 6'h20) cnt_r <= cnt_r + 6'h01;
            end else if (cnt_r == 6'h20) begin
              state_r <= S_HDR;
              cnt_r <= 6'h00;
            end else begin
              cnt_r <= 6'h00;
            end
          end
        end
        S_HDR: if (rise) begin
          hdr_r <= {hdr_r[12:0], mdioIn};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h0c) begin
            cnt_r <= 6'h00;
            regAddr <= {hdr_r[3:0], mdioIn};
            // twelve bits held: start one at [11], op at [10:9], phy at [8:4]
            if (hdr_r[11] != 1'h1 || hdr_r[8:4] != phyAddr) state_r <= S_PRE;
            else if (hdr_r[10:9] == `PBMC_MDIO_OP_RD) begin
              state_r <= S_TA;
              rdStb <= 1'h1;
            end else if (hdr_r[10:9] == `PBMC_MDIO_OP_WR) state_r <= S_TA;
            else state_r <= S_PRE;
          end
        end
        S_TA: begin
          // thirteen bits held now, so op sits at [11:10]
          if (hdr_r[11:10] == `PBMC_MDIO_OP_RD) begin
            // first turnaround bit left to the pull-up, zero in the second
            if (fall) begin
              cnt_r <= cnt_r + 6'h01;
              if (cnt_r == 6'h01) begin
                mdioOe <= 1'h1;
                mdioOut <= 1'h0;
                shift_r <= rdData;
              end else if (cnt_r == 6'h02) begin
                cnt_r <= 6'h00;
                state_r <= S_RDAT;
                mdioOut <= shift_r[15];
                shift_r <= {shift_r[14:0], 1'h0};
              end
            end
          end else if (rise) begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h01) begin
              cnt_r <= 6'h00;
              state_r <= S_WDAT;
            end
          end
        end
        S_WDAT: if (rise) begin
          shift_r <= {shift_r[14:0], mdioIn};
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h0f) begin
            wrData <= {shift_r[14:0], mdioIn};
            wrStb <= 1'h1;
            cnt_r <= 6'h00;
            state_r <= S_PRE;
          end
        end
        S_RDAT: if (fall) begin
          cnt_r <= cnt_r + 6'h01;
          mdioOut <= shift_r[15];
          shift_r <= {shift_r[14:0], 1'h0};
          if (cnt_r == 6'h0f) begin
            mdioOe <= 1'h0;
            cnt_r <= 6'h00;
            state_r <= S_PRE;
          end
        end
        default: state_r <= S_PRE;
      endcase
    end
  end
endmodule // pbmc_mdio_slave

//--- rtl/pbmc_basic_mode_control.v
// basic mode control register of a 10/100 phy, reached over the management pins
// assumes mii and mdc are synchronous to mclk; straps steady while reset_n is low
// Functional notes
// RULE_01: writing one to bit 15 returns standard registers to defaults
// RULE_02: bit 15 reads one during reset and clears itself when done
// RULE_03: vendor extended registers keep their contents over software reset
// RULE_04: bit 14 loops mii transmit nibbles back onto receive outputs
// RULE_05: forced mode runs 100 Mbps with bit 13 set, else 10 Mbps
// RULE_06: autonegotiation off takes speed and duplex only from bits 13 and 8
// RULE_07: speed and autonegotiation enable default from straps, else one
// RULE_08: bit 11 powers down the phy; management access stays alive
// RULE_09: effective power down is bit 11 or the external low pin
// RULE_10: asserting the external low power down pin sets bit 11
// RULE_11: bit 10 isolates the mii while management still works
// RULE_12: bit 9 restarts autonegotiation; ignored when autonegotiation disabled
// RULE_13: bit 9 reads one until autonegotiation starts, then self clears
// RULE_14: writing bit 9 to zero does not disturb running autonegotiation
// RULE_15: forced duplex from bit 8, full when one; defaults from strap
// RULE_16: register is management address zero; bits 14,11,10,9,15 reset zero
`timescale 1ns/100ps
`include "pbmc_map.vh"
module pbmc_basic_mode_control #(
  parameter RESET_CYCLES = `PBMC_RESET_CYC
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // straps
  input wire strapSpeed,
  input wire strapAnEn,
  input wire strapDuplex,
  input wire [4:0] phyAddr,
  // management pins
  input wire mdc,
  input wire mdioIn,
  output reg mdioOut,
  output reg mdioOe,
  // external power down, active low
  input wire irq_or_powerdown_pin_n,
  // autonegotiation engine
  input wire anStarted,
  output reg anRestart,
  // mii from mac and from the line side
  input wire [3:0] miiTxd,
  input wire miiTxEn,
  input wire [3:0] lineRxd,
  input wire lineRxDv,
  output reg [3:0] miiRxd,
  output reg miiRxDv,
  output reg miiRxdOe,
  // operating state
  output reg speed100,
  output reg fullDuplex,
  output reg anEnable,
  output reg powerDown,
  output reg pcsReset,
  // extended register, kept over soft reset
  input wire [15:0] vendorWrData,
  input wire vendorWrStb,
  output reg [15:0] vendorReg
);
  reg loop_r, speed_r, anEn_r, pdown_r, iso_r, restart_r, duplex_r, colTest_r;
  reg strapSpeed_r, strapAnEn_r, strapDuplex_r, strapTaken_r;
  reg [15:0] rstCnt_r;
  reg [15:0] rstCnt_nxt;
  wire slvOut, slvOe, wrStb;
  reg [15:0] rdData;
  wire [4:0] regAddr;
  wire [15:0] wrData;
  wire softRst = rstCnt_r != 16'h0000;
  wire pinDown = ~irq_or_powerdown_pin_n;
  wire hitBmc = wrStb && regAddr == `PBMC_ADDR_BMC;
  wire effDown = pdown_r | pinDown; // RULE_09

  // only address zero is implemented; every other address reads as zero
  always @* begin
    rdData = 16'h0000;
    case (regAddr)
      `PBMC_ADDR_BMC: begin
        rdData[`PBMC_BIT_RESET] = softRst; // RULE_02
        rdData[`PBMC_BIT_LOOP] = loop_r;
        rdData[`PBMC_BIT_SPEED] = speed_r;
        rdData[`PBMC_BIT_ANEN] = anEn_r;
        rdData[`PBMC_BIT_PDOWN] = pdown_r;
        rdData[`PBMC_BIT_ISO] = iso_r;
        rdData[`PBMC_BIT_RESTART] = restart_r; // RULE_13
        rdData[`PBMC_BIT_DUPLEX] = duplex_r;
        rdData[`PBMC_BIT_COLTEST] = colTest_r;
      end
      default: rdData = 16'h0000;
    endcase
  end

  pbmc_mdio_slave uSlave (
    .mclk(mclk),
    .reset_n(reset_n),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(slvOut),
    .mdioOe(slvOe),
    .phyAddr(phyAddr),
    .rdData(rdData),
    .wrStb(wrStb),
    .rdStb(),
    .regAddr(regAddr),
    .wrData(wrData)
  ); // RULE_16 RULE_08 RULE_11

  always @* begin
    rstCnt_nxt = rstCnt_r;
    if (hitBmc && wrData[`PBMC_BIT_RESET] && !softRst)
      rstCnt_nxt = RESET_CYCLES[15:0]; // RULE_01
    else if (softRst)
      rstCnt_nxt = rstCnt_r - 16'h0001; // RULE_02
  end

  // straps caught on the first clock after release, never under async reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strapTaken_r <= 1'h0;
      strapSpeed_r <= `PBMC_RST_SPEED;
      strapAnEn_r <= `PBMC_RST_ANEN;
      strapDuplex_r <= `PBMC_RST_DUPLEX;
    end else if (!strapTaken_r) begin
      strapTaken_r <= 1'h1;
      strapSpeed_r <= strapSpeed; // RULE_07
      strapAnEn_r <= strapAnEn; // RULE_07
      strapDuplex_r <= strapDuplex; // RULE_15
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstCnt_r <= 16'h0000;
      loop_r <= `PBMC_RST_ZERO;
      speed_r <= `PBMC_RST_SPEED;
      anEn_r <= `PBMC_RST_ANEN;
      pdown_r <= `PBMC_RST_ZERO;
      iso_r <= `PBMC_RST_ZERO;
      duplex_r <= `PBMC_RST_DUPLEX;
      colTest_r <= `PBMC_RST_ZERO;
    end else begin
      rstCnt_r <= rstCnt_nxt;
      if (!strapTaken_r || softRst) begin
        // defaults while held; strap values land on the same edge as their capture
        loop_r <= 1'h0; // RULE_01
        speed_r <= strapTaken_r ? strapSpeed_r : strapSpeed;
        anEn_r <= strapTaken_r ? strapAnEn_r : strapAnEn;
        duplex_r <= strapTaken_r ? strapDuplex_r : strapDuplex;
        pdown_r <= pinDown; // RULE_10
        iso_r <= 1'h0;
        colTest_r <= 1'h0;
      end else begin
        if (hitBmc) begin
          loop_r <= wrData[`PBMC_BIT_LOOP]; // RULE_04
          speed_r <= wrData[`PBMC_BIT_SPEED]; // RULE_05
          anEn_r <= wrData[`PBMC_BIT_ANEN]; // RULE_06
          iso_r <= wrData[`PBMC_BIT_ISO]; // RULE_11
          duplex_r <= wrData[`PBMC_BIT_DUPLEX]; // RULE_15
          colTest_r <= wrData[`PBMC_BIT_COLTEST];
        end
        // pin assertion wins over a clearing write
        if (pinDown) pdown_r <= 1'h1; // RULE_10
        else if (hitBmc) pdown_r <= wrData[`PBMC_BIT_PDOWN]; // RULE_08
      end
    end
  end

  // bit 9 written zero never clears a pending restart; the started event, autonegotiation off or soft reset does
  // set beats the started and autonegotiation-off clears in one cycle so a fresh request is not lost to them; soft reset beats set
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      restart_r <= `PBMC_RST_ZERO;
    end else if (!strapTaken_r || softRst) begin
      restart_r <= 1'h0;
    end else if (hitBmc && wrData[`PBMC_BIT_RESTART] && wrData[`PBMC_BIT_ANEN]) begin
      restart_r <= 1'h1; // RULE_12
    end else if (restart_r && (anStarted || !anEn_r)) begin
      restart_r <= 1'h0; // RULE_13 RULE_14
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vendorReg <= 16'h0000;
    end else if (vendorWrStb) begin
      vendorReg <= vendorWrData; // RULE_03
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mdioOut <= 1'h0;
      mdioOe <= 1'h0;
      anRestart <= 1'h0;
      miiRxd <= 4'h0;
      miiRxDv <= 1'h0;
      miiRxdOe <= 1'h0;
      speed100 <= `PBMC_RST_SPEED;
      fullDuplex <= `PBMC_RST_DUPLEX;
      anEnable <= `PBMC_RST_ANEN;
      powerDown <= 1'h0;
      pcsReset <= 1'h0;
    end else begin
      mdioOut <= slvOut;
      mdioOe <= slvOe;
      anRestart <= restart_r && anEn_r && !effDown; // RULE_12
      speed100 <= speed_r; // RULE_05 RULE_06
      fullDuplex <= duplex_r; // RULE_06 RULE_15
      anEnable <= anEn_r;
      powerDown <= effDown; // RULE_08 RULE_09
      pcsReset <= softRst; // RULE_01
      miiRxdOe <= !iso_r; // RULE_11
      // isolate also floats the receive pins; power down only silences them
      if (iso_r || effDown) begin
        miiRxd <= 4'h0;
        miiRxDv <= 1'h0;
      end else if (loop_r) begin
        miiRxd <= miiTxd; // RULE_04
        miiRxDv <= miiTxEn;
      end else begin
        miiRxd <= lineRxd;
        miiRxDv <= lineRxDv;
      end
    end
  end
endmodule // pbmc_basic_mode_control

//--- sim/pbmc_smi_master.sv
// station management master model: builds frames with full preamble
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/100ps
module pbmc_smi_master #(
  parameter [4:0] PHY = 5'h01
) (
  // clock
  input wire mclk,
  // shared data line as seen on the wire
  input wire mdioWire,
  // master drive
  output reg mdc,
  output reg mDrv,
  output reg mBit
);
  initial begin
    mdc = 1'h0;
    mDrv = 1'h0;
    mBit = 1'h1;
  end
  // eight mclk per bit keeps each mdc phase well above two mclk
  task automatic xfer(input [1:0] op, input [4:0] ra, input [15:0] wd, output [15:0] rd);
    reg [63:0] f;
    integer i;
    f = {32'hffffffff, 2'h1, op, PHY, ra, 2'h2, wd};
    rd = 16'h0000;
    for (i = 63; i >= 0; i = i - 1) begin
      @(posedge mclk);
      mDrv <= !(op == 2'h2 && i < 18);
      mBit <= f[i];
      repeat (3) @(posedge mclk);
      mdc <= 1'h1;
      repeat (4) @(posedge mclk);
      if (i < 16)
        rd[i] = mdioWire;
      mdc <= 1'h0;
    end
    @(posedge mclk);
    mDrv <= 1'h0;
  endtask
endmodule // pbmc_smi_master

//--- sim/pbmc_bmc_props.sv
// port assertions for the basic mode control block
// assumes straps steady over the whole run
`timescale 1ns/100ps
module pbmc_bmc_props #(
  parameter RESET_CYCLES = 100
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // inputs watched
  input wire strapSpeed,
  input wire strapAnEn,
  input wire strapDuplex,
  input wire mdc,
  input wire irq_or_powerdown_pin_n,
  input wire anStarted,
  input wire vendorWrStb,
  // outputs watched
  input wire mdioOe,
  input wire anRestart,
  input wire [3:0] miiRxd,
  input wire miiRxDv,
  input wire miiRxdOe,
  input wire speed100,
  input wire fullDuplex,
  input wire anEnable,
  input wire powerDown,
  input wire pcsReset,
  input wire [15:0] vendorReg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  reg [15:0] hiCnt_r;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      hiCnt_r <= 16'h0000;
    else
      hiCnt_r <= pcsReset ? hiCnt_r + 16'h0001 : 16'h0000;
  end
  property p_pd; $fell(irq_or_powerdown_pin_n) |-> ##[1:4] powerDown; endproperty
  a_pd: assert property (p_pd) else $error("pin did not power down");
  property p_iso; !miiRxdOe |-> miiRxd == 4'h0 && !miiRxDv; endproperty
  a_iso: assert property (p_iso) else $error("receive active while isolated");
  property p_an; anRestart |-> anEnable; endproperty
  a_an: assert property (p_an) else $error("restart without autoneg");
  property p_clr; anStarted && anRestart |-> ##[1:3] !anRestart; endproperty
  a_clr: assert property (p_clr) else $error("restart not cleared");
  property p_len;
    $fell(pcsReset) |-> hiCnt_r >= RESET_CYCLES && hiCnt_r <= RESET_CYCLES + 2;
  endproperty
  a_len: assert property (p_len) else $error("soft reset length wrong");
  property p_def;
    $fell(pcsReset) |-> ##[0:3] anEnable == strapAnEn && speed100 == strapSpeed
      && fullDuplex == strapDuplex;
  endproperty
  a_def: assert property (p_def) else $error("defaults not reloaded");
  property p_oe; $rose(mdioOe) |-> !mdc; endproperty
  a_oe: assert property (p_oe) else $error("drive began with mdc high");
  property p_ven; !vendorWrStb |=> $stable(vendorReg); endproperty
  a_ven: assert property (p_ven) else $error("extended register changed");
endmodule // pbmc_bmc_props

//--- sim/tb_pbmc_basic_mode_control.sv
// self-checking bench for the basic mode control block
// assumes a management master model and a pulled-up data line
`timescale 1ns/100ps
module tb_pbmc_basic_mode_control;
  localparam RC = 600;
  reg mclk, reset_n, irq_or_powerdown_pin_n, anStarted, miiTxEn, lineRxDv, vendorWrStb;
  reg [3:0] miiTxd, lineRxd;
  reg [15:0] vendorWrData, rd;
  wire mdc, mDrv, mBit, mdioOut, mdioOe, anRestart, miiRxDv, miiRxdOe;
  wire speed100, fullDuplex, anEnable, powerDown, pcsReset;
  wire [3:0] miiRxd;
  wire [15:0] vendorReg;
  wire mdioIn = mdioOe ? mdioOut : (mDrv ? mBit : 1'h1);
  integer failures, n_compared;
  pbmc_smi_master u_pbmc_smi_master (.mclk(mclk), .mdioWire(mdioIn), .mdc(mdc),
    .mDrv(mDrv), .mBit(mBit));
  pbmc_basic_mode_control #(.RESET_CYCLES(RC)) u_pbmc_basic_mode_control (.mclk(mclk),
    .reset_n(reset_n), .strapSpeed(1'h1), .strapAnEn(1'h1), .strapDuplex(1'h0),
    .phyAddr(5'h01), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .irq_or_powerdown_pin_n(irq_or_powerdown_pin_n), .anStarted(anStarted),
    .anRestart(anRestart), .miiTxd(miiTxd), .miiTxEn(miiTxEn), .lineRxd(lineRxd),
    .lineRxDv(lineRxDv), .miiRxd(miiRxd), .miiRxDv(miiRxDv), .miiRxdOe(miiRxdOe),
    .speed100(speed100), .fullDuplex(fullDuplex), .anEnable(anEnable),
    .powerDown(powerDown), .pcsReset(pcsReset), .vendorWrData(vendorWrData),
    .vendorWrStb(vendorWrStb), .vendorReg(vendorReg));
  task chk(input [15:0] seen, input [15:0] exp, input string w);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task wr(input [15:0] d);
    u_pbmc_smi_master.xfer(2'h1, 5'h00, d, rd);
    repeat (4) @(posedge mclk);
  endtask
  task rdr(input [4:0] a, input [15:0] e);
    u_pbmc_smi_master.xfer(2'h2, a, 16'h0000, rd);
    chk(rd, e, "readback");
  endtask
  task t_defaults;
    rdr(5'h00, 16'h3000);
    chk({anEnable, speed100, fullDuplex}, 3'h6, "strap state");
    rdr(5'h03, 16'h0000);
    u_pbmc_smi_master.xfer(2'h1, 5'h03, 16'hffff, rd);
    rdr(5'h00, 16'h3000);
  endtask
  task t_forced;
    miiTxd <= 4'ha;
    miiTxEn <= 1'h1;
    wr(16'h4100);
    chk({miiRxDv, miiRxd}, 5'h1a, "loopback");
    chk({anEnable, speed100, fullDuplex}, 3'h1, "forced 10 full");
    wr(16'h2400);
    chk({miiRxdOe, speed100, fullDuplex}, 3'h2, "isolate 100 half");
    rdr(5'h00, 16'h2400);
    wr(16'h0000);
    chk({miiRxDv, miiRxd}, 5'h05, "line path");
  endtask
  task t_restart;
    wr(16'h1200);
    chk(anRestart, 1'h1, "restart");
    rdr(5'h00, 16'h1200);
    wr(16'h1000);
    chk(anRestart, 1'h1, "restart kept");
    anStarted <= 1'h1;
    @(posedge mclk);
    anStarted <= 1'h0;
    repeat (3) @(posedge mclk);
    rdr(5'h00, 16'h1000);
    wr(16'h0200);
    chk(anRestart, 1'h0, "restart ignored");
  endtask
  task t_pdown;
    wr(16'h0000);
    irq_or_powerdown_pin_n <= 1'h0;
    repeat (5) @(posedge mclk);
    chk(powerDown, 1'h1, "pin down");
    irq_or_powerdown_pin_n <= 1'h1;
    rdr(5'h00, 16'h0800);
    wr(16'h0000);
    chk(powerDown, 1'h0, "power up");
    wr(16'h0800);
    chk(powerDown, 1'h1, "bit down");
    chk({miiRxDv, miiRxd}, 5'h00, "quiet when down");
    rdr(5'h00, 16'h0800);
  endtask
  task t_soft;
    vendorWrData <= 16'h5a5a;
    vendorWrStb <= 1'h1;
    @(posedge mclk);
    vendorWrStb <= 1'h0;
    wr(16'h4000);
    wr(16'h8000);
    chk(pcsReset, 1'h1, "soft reset");
    u_pbmc_smi_master.xfer(2'h2, 5'h00, 16'h0000, rd);
    chk(rd[15], 1'h1, "busy bit");
    repeat (RC) @(posedge mclk);
    rdr(5'h00, 16'h3000);
    chk(vendorReg, 16'h5a5a, "extended");
  endtask
  task summarize;
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // roughly 22 frames of 513 cycles plus waits; over three times that is a hang
  initial begin
    #400000;
    failures = failures + 1;
    summarize;
  end
  initial begin
    failures = 0;
    n_compared = 0;
    reset_n = 1'h0;
    irq_or_powerdown_pin_n = 1'h1;
    anStarted = 1'h0;
    miiTxd = 4'h0;
    miiTxEn = 1'h0;
    lineRxd = 4'h5;
    lineRxDv = 1'h0;
    vendorWrData = 16'h0000;
    vendorWrStb = 1'h0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (3) @(posedge mclk);
    t_defaults;
    t_forced;
    t_restart;
    t_pdown;
    t_soft;
    summarize;
  end
endmodule // tb_pbmc_basic_mode_control
bind pbmc_basic_mode_control pbmc_bmc_props #(.RESET_CYCLES(RESET_CYCLES)) u_pbmc_bmc_props (
  .mclk(mclk), .reset_n(reset_n), .strapSpeed(strapSpeed), .strapAnEn(strapAnEn),
  .strapDuplex(strapDuplex), .mdc(mdc), .irq_or_powerdown_pin_n(irq_or_powerdown_pin_n),
  .anStarted(anStarted), .vendorWrStb(vendorWrStb), .mdioOe(mdioOe), .anRestart(anRestart),
  .miiRxd(miiRxd), .miiRxDv(miiRxDv), .miiRxdOe(miiRxdOe), .speed100(speed100),
  .fullDuplex(fullDuplex), .anEnable(anEnable), .powerDown(powerDown),
  .pcsReset(pcsReset), .vendorReg(vendorReg));
